//--- logic/usbpc_pkg.sv
// Package: constants of the USB power and control block.
// Assumes a 25 MHz bus clock.
package usbpc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_PWR  = 8'h00;
    localparam logic [7:0] OFS_CTL  = 8'h04;
    localparam logic [7:0] OFS_TOK  = 8'h08;
    localparam logic [7:0] OFS_IST  = 8'h0c;
    localparam logic [7:0] OFS_IMSK = 8'h10;

    // Power control fields
    localparam int PWR_ON_B    = 0;
    localparam int PWR_SUSP_B  = 1;
    localparam int PWR_BUSY_B  = 3;
    localparam int PWR_GUARD_B = 4;
    localparam int PWR_ACT_B   = 7;

    // Module control fields
    localparam int CTL_EN_B     = 0;
    localparam int CTL_PPRST_B  = 1;
    localparam int CTL_RESUME_B = 2;
    localparam int CTL_HOST_B   = 3;
    localparam int CTL_FRAME_TOKEN_ENABLE_B  = 4;
    localparam int CTL_TBUSY_B  = 5;

    // Interrupt status and mask fields
    localparam int IRQ_ACT_B  = 0;
    localparam int IRQ_SOF_B  = 1;
    localparam int IRQ_TOK_B  = 2;
    localparam int IRQ_EOP_B  = 3;
    localparam int IRQ_W      = 4;
    localparam int TOK_W      = 8;

    localparam logic [31:0]    RST_WORD = 32'h0000_0000;
    localparam logic [IRQ_W-1:0] RST_IRQ = 4'h0;

    // Timing
    localparam int CLK_MHZ         = 25;
    localparam int SOF_PERIOD_US   = 1000;
    localparam int SOF_CYC         = SOF_PERIOD_US * CLK_MHZ;
    localparam int LS_EOP_NS       = 1333;
    localparam int LS_EOP_CYC      = (LS_EOP_NS * CLK_MHZ + 999) / 1000;
    localparam int BUSY_SETTLE_CYC = 8;

    typedef enum {SEQ_IDLE, SEQ_RESUME, SEQ_EOP} usbpc_seq_t;
endpackage : usbpc_pkg

//--- logic/usbpc_ctl_if.sv
// Interface: control between register top, frame timer and sequencer.
// All signals in the hclk domain.
`timescale 1ns/1ps
interface usbpc_ctl_if;
    logic host_rst;
    logic sof_go;
    logic sof_pulse;
    logic tok_req;
    logic tok_start;
    logic tok_busy;
    logic tok_done;
    logic tok_ended;
    logic resume_req;
    logic host_mode;
    logic powered;
    logic resume_drive;
    logic eop_drive;
    logic eop_done;

    modport top   (output host_rst, sof_go, tok_req, tok_done, resume_req, host_mode, powered,
                   input  sof_pulse, tok_start, tok_busy, tok_ended, resume_drive, eop_drive,
                          eop_done);
    modport timer (input host_rst, sof_go, output sof_pulse);
    modport seq   (input  host_rst, tok_req, tok_done, resume_req, host_mode, powered,
                   output tok_start, tok_busy, tok_ended, resume_drive, eop_drive, eop_done);
endinterface : usbpc_ctl_if

//--- logic/usbpc_frame_timer.sv
// Frame timer: one-cycle frame pulse per period while enabled.
// Assumes sof_go only in host mode while running.
`timescale 1ns/1ps
module usbpc_frame_timer #(
    parameter int SOF_CYC = usbpc_pkg::SOF_CYC
) (
    input  wire logic  hclk,
    input  wire logic  hresetn,
    usbpc_ctl_if.timer ctl
);
    import usbpc_pkg::*;

    localparam int CW = $clog2(SOF_CYC);
    localparam logic [CW-1:0] LAST = CW'(SOF_CYC - 1);

    logic [CW-1:0] cnt_r;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_r <= '0;
        end
        else if (ctl.host_rst || !ctl.sof_go)
        begin
            cnt_r <= '0; // RULE11
        end
        else if (cnt_r == LAST)
        begin
            cnt_r <= '0;
        end
        else
        begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctl.sof_pulse <= 1'b0;
        end
        else
        begin
            ctl.sof_pulse <= ctl.sof_go && !ctl.host_rst && (cnt_r == LAST); // RULE9
        end
    end
endmodule : usbpc_frame_timer

//--- logic/usbpc_link_seq.sv
// Link sequencer: token busy and resume / low-speed EOP.
// Assumes tok_done is a one-cycle pulse.
`timescale 1ns/1ps
module usbpc_link_seq #(
    parameter int EOP_CYC = usbpc_pkg::LS_EOP_CYC
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    usbpc_ctl_if.seq  ctl
);
    import usbpc_pkg::*;

    localparam int EW = $clog2(EOP_CYC + 1);
    localparam logic [EW-1:0] EOP_LAST = EW'(EOP_CYC - 1);

    usbpc_seq_t    st_r;
    logic [EW-1:0] eop_cnt_r;

    // Token busy; the top drops requests while busy
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctl.tok_busy  <= 1'b0;
            ctl.tok_start <= 1'b0;
            ctl.tok_ended <= 1'b0;
        end
        else
        begin
            ctl.tok_start <= ctl.tok_req && !ctl.tok_busy && !ctl.host_rst;
            ctl.tok_ended <= ctl.tok_busy && ctl.tok_done && !ctl.host_rst;
            if (ctl.host_rst || !ctl.powered)
                ctl.tok_busy <= 1'b0; // RULE11
            else if (ctl.tok_req && !ctl.tok_busy)
                ctl.tok_busy <= 1'b1;
            else if (ctl.tok_done)
                ctl.tok_busy <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_r      <= SEQ_IDLE;
            eop_cnt_r <= '0;
            ctl.eop_done <= 1'b0;
        end
        else
        begin
            ctl.eop_done <= 1'b0;
            case (st_r)
                SEQ_IDLE:
                begin
                    if (ctl.resume_req && ctl.powered)
                        st_r <= SEQ_RESUME;
                end
                SEQ_RESUME:
                begin
                    if (!ctl.powered)
                        st_r <= SEQ_IDLE;
                    else if (!ctl.resume_req && ctl.host_mode)
                    begin
                        st_r      <= SEQ_EOP; // RULE13
                        eop_cnt_r <= '0;
                    end
                    else if (!ctl.resume_req)
                        st_r <= SEQ_IDLE;
                end
                SEQ_EOP:
                begin
                    if (!ctl.powered || ctl.host_rst)
                        st_r <= SEQ_IDLE;
                    else if (eop_cnt_r == EOP_LAST)
                    begin
                        st_r         <= SEQ_IDLE;
                        ctl.eop_done <= 1'b1;
                    end
                    else
                        eop_cnt_r <= eop_cnt_r + 1'b1;
                end
                default:
                    st_r <= SEQ_IDLE;
            endcase
        end
    end

    assign ctl.resume_drive = (st_r == SEQ_RESUME);
    assign ctl.eop_drive    = (st_r == SEQ_EOP);
endmodule : usbpc_link_seq

//--- logic/usbpc_top.sv
// Top: AHB-Lite registers and power gating of the USB control block.
// Assumes single-word transfers and link inputs on hclk.
//
// Contract
// RULE1: Activity pending flags bus activity not yet raised as interrupt.
// RULE2: Sleep guard blocks sleep on activity or pending notification.
// RULE3: Busy reads one while enabled or settling after disable.
// RULE4: Suspend gates the 48 MHz clock, transceiver to low power.
// RULE5: Power off holds outputs idle, frees pins, stops analog. (host_reset is not gated by power and can still pulse while off.)
// RULE6: Software ignores status, skips writes while off and busy.
// RULE7: Ping-pong reset forces all buffer pointers to even bank.
// RULE8: Function mode enable turns module and support on.
// RULE9: Host mode frame tokens every 1 ms when enabled.
// RULE10: Software waits for token busy clear before next token.
// RULE11: Host-mode select change resets host control logic.
// RULE12: Software holds resume 10 ms as function, 25 ms as host.
// RULE13: Host mode resume clear appends low-speed end-of-packet.
// RULE14: Power-control bits 31-8, 6, 5 and 2 read zero.
`timescale 1ns/1ps
module usbpc_top
    import usbpc_pkg::*;
#(
    parameter int NUM_EP     = 16,
    parameter int SOF_CYCLES = usbpc_pkg::SOF_CYC,
    parameter int SETTLE_CYC = usbpc_pkg::BUSY_SETTLE_CYC
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic [31:0]            hrdata,
    output logic                   hresp,
    input  wire logic              bus_activity,
    input  wire logic              token_done,
    input  wire logic [NUM_EP-1:0] buf_done,
    output logic                   usb_clk_en,
    output logic                   xcvr_low_power,
    output logic                   pins_usb_owned,
    output logic                   analog_en,
    output logic                   module_run,
    output logic                   sleep_block,
    output logic [NUM_EP-1:0]      pp_odd,
    output logic                   host_reset,
    output logic                   sof_token,
    output logic                   token_start,
    output logic [TOK_W-1:0]       token_code,
    output logic                   resume_drive,
    output logic                   ls_eop_drive,
    output logic                   irq
);
    import usbpc_pkg::*;

    localparam int SW = $clog2(SETTLE_CYC + 1);
    localparam logic [SW-1:0] SETTLE_LD = SW'(SETTLE_CYC);

    usbpc_ctl_if ctl ();

    // Control registers
    logic power_on_r, suspend_r, guard_r;
    logic enable_r, pprst_r, resume_r, host_mode_r, sof_en_r;
    logic act_pend_r;
    logic [SW-1:0]    settle_r;
    logic [IRQ_W-1:0] ist_r, imsk_r, ist_set, ist_clr;
    logic [TOK_W-1:0] tok_code_r;
    logic             tok_req_r, host_rst_r;

    // Bus data phase
    logic       dp_wr_r;
    logic [7:0] dp_addr_r;
    logic       addr_ok;
    logic       busy;

    function automatic logic [31:0] read_word(input logic [7:0] a);
        logic [31:0] w;
        w = RST_WORD;
        case (a)
            OFS_PWR:
            begin
                w[PWR_ACT_B]   = act_pend_r; // RULE14
                w[PWR_GUARD_B] = guard_r;
                w[PWR_BUSY_B]  = busy;
                w[PWR_SUSP_B]  = suspend_r;
                w[PWR_ON_B]    = power_on_r;
            end
            OFS_CTL:
            begin
                w[CTL_EN_B]     = enable_r;
                w[CTL_PPRST_B]  = pprst_r;
                w[CTL_RESUME_B] = resume_r;
                w[CTL_HOST_B]   = host_mode_r;
                w[CTL_FRAME_TOKEN_ENABLE_B]  = sof_en_r;
                w[CTL_TBUSY_B]  = ctl.tok_busy;
            end
            OFS_TOK:  w[TOK_W-1:0] = tok_code_r;
            OFS_IST:  w[IRQ_W-1:0] = ist_r;
            OFS_IMSK: w[IRQ_W-1:0] = imsk_r;
            default:  w = RST_WORD;
        endcase
        return w;
    endfunction : read_word

    function automatic logic wr_hit(input logic [7:0] ofs);
        return dp_wr_r && (dp_addr_r == ofs);
    endfunction : wr_hit

    assign addr_ok = hsel && htrans[1] && hready;
    assign busy    = enable_r || (settle_r != '0); // RULE3

    // Zero wait, always OKAY, registered read data
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_wr_r   <= 1'b0;
            dp_addr_r <= '0;
            hrdata    <= RST_WORD;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            dp_wr_r   <= addr_ok && hwrite;
            dp_addr_r <= {haddr[7:2], 2'b00};
            if (addr_ok && !hwrite)
                hrdata <= read_word({haddr[7:2], 2'b00});
        end
    end

    // Power control register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            power_on_r <= 1'b0;
            suspend_r  <= 1'b0;
            guard_r    <= 1'b0;
        end
        else if (wr_hit(OFS_PWR))
        begin
            power_on_r <= hwdata[PWR_ON_B];
            suspend_r  <= hwdata[PWR_SUSP_B];
            guard_r    <= hwdata[PWR_GUARD_B];
        end
    end

    // Module control; writes while off and busy are stored
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            enable_r    <= 1'b0;
            pprst_r     <= 1'b0;
            resume_r    <= 1'b0;
            host_mode_r <= 1'b0;
            sof_en_r    <= 1'b0;
            host_rst_r  <= 1'b0;
        end
        else
        begin
            host_rst_r <= 1'b0;
            if (wr_hit(OFS_CTL))
            begin
                enable_r    <= hwdata[CTL_EN_B];
                pprst_r     <= hwdata[CTL_PPRST_B];
                resume_r    <= hwdata[CTL_RESUME_B];
                host_mode_r <= hwdata[CTL_HOST_B];
                sof_en_r    <= hwdata[CTL_FRAME_TOKEN_ENABLE_B];
                host_rst_r  <= hwdata[CTL_HOST_B] != host_mode_r; // RULE11
            end
        end
    end

    // Settling window after disable keeps busy high
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            settle_r <= '0;
        else if (enable_r)
            settle_r <= SETTLE_LD; // RULE3
        else if (settle_r != '0)
            settle_r <= settle_r - 1'b1;
    end

    // Token command: a write while busy is dropped, not queued
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tok_code_r <= '0;
            tok_req_r  <= 1'b0;
        end
        else
        begin
            tok_req_r <= 1'b0;
            if (wr_hit(OFS_TOK) && !ctl.tok_busy && !tok_req_r) // RULE10
            begin
                tok_code_r <= hwdata[TOK_W-1:0];
                tok_req_r  <= power_on_r;
            end
        end
    end

    // Pending until the status bit takes it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            act_pend_r <= 1'b0;
        else if (bus_activity && power_on_r)
            act_pend_r <= 1'b1; // RULE1
        else if (ist_r[IRQ_ACT_B])
            act_pend_r <= 1'b0; // RULE1
    end

    // Sticky status; read clears, a set in the same cycle wins
    always_comb
    begin
        ist_set            = '0;
        ist_set[IRQ_ACT_B] = act_pend_r;
        ist_set[IRQ_SOF_B] = ctl.sof_pulse;
        ist_set[IRQ_TOK_B] = ctl.tok_ended;
        ist_set[IRQ_EOP_B] = ctl.eop_done;
        ist_clr = (addr_ok && !hwrite && ({haddr[7:2], 2'b00} == OFS_IST)) ? '1 : '0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ist_r  <= RST_IRQ;
            imsk_r <= RST_IRQ;
            irq    <= 1'b0;
        end
        else
        begin
            ist_r <= (ist_r & ~ist_clr) | ist_set;
            if (wr_hit(OFS_IMSK))
                imsk_r <= hwdata[IRQ_W-1:0];
            irq <= |(ist_r & imsk_r);
        end
    end

    // Ping-pong pointers toggle per finished buffer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pp_odd <= '0;
        else if (pprst_r)
            pp_odd <= '0; // RULE7
        else
            pp_odd <= pp_odd ^ buf_done;
    end

    // Power, suspend and pin ownership
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            usb_clk_en     <= 1'b0;
            xcvr_low_power <= 1'b1;
            pins_usb_owned <= 1'b0;
            analog_en      <= 1'b0;
            module_run     <= 1'b0;
            sleep_block    <= 1'b0;
        end
        else
        begin
            usb_clk_en     <= power_on_r && !suspend_r; // RULE4
            xcvr_low_power <= !power_on_r || suspend_r; // RULE4
            pins_usb_owned <= power_on_r; // RULE5
            analog_en      <= power_on_r; // RULE5
            module_run     <= power_on_r && enable_r; // RULE8
            sleep_block    <= guard_r && (bus_activity || act_pend_r || (|ist_r)); // RULE2
        end
    end

    // Link outputs except host_reset held inactive while off
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            host_reset   <= 1'b0;
            sof_token    <= 1'b0;
            token_start  <= 1'b0;
            token_code   <= '0;
            resume_drive <= 1'b0;
            ls_eop_drive <= 1'b0;
        end
        else
        begin
            host_reset   <= host_rst_r;
            sof_token    <= power_on_r && ctl.sof_pulse; // RULE5
            token_start  <= power_on_r && ctl.tok_start;
            token_code   <= power_on_r ? tok_code_r : '0;
            resume_drive <= power_on_r && ctl.resume_drive;
            ls_eop_drive <= power_on_r && ctl.eop_drive; // RULE13
        end
    end

    assign ctl.host_rst   = host_rst_r;
    assign ctl.sof_go     = power_on_r && enable_r && host_mode_r && sof_en_r && !suspend_r;
    assign ctl.tok_req    = tok_req_r;
    assign ctl.tok_done   = token_done;
    assign ctl.resume_req = resume_r;
    assign ctl.host_mode  = host_mode_r;
    assign ctl.powered    = power_on_r;

    usbpc_frame_timer #(
        .SOF_CYC (SOF_CYCLES)
    ) u_timer (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ctl     (ctl)
    );

    usbpc_link_seq #(
        .EOP_CYC (LS_EOP_CYC)
    ) u_seq (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ctl     (ctl)
    );
endmodule : usbpc_top

//--- dv/usbpc_top_asserts.sv
// Checker: port-level properties of usbpc_top.
// Bound onto usbpc_top; sees only its ports.
`timescale 1ns/1ps
module usbpc_top_asserts
    import usbpc_pkg::*;
#(
    parameter int SOF_CYCLES = 25000
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        usb_clk_en,
    input wire logic        xcvr_low_power,
    input wire logic        pins_usb_owned,
    input wire logic        analog_en,
    input wire logic        module_run,
    input wire logic        host_reset,
    input wire logic        sof_token,
    input wire logic        token_start,
    input wire logic        resume_drive,
    input wire logic        ls_eop_drive
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    int unsigned sof_gap_r;
    int unsigned eop_len_r;

    // Gap saturates so a restarted frame timer never looks early
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            sof_gap_r <= SOF_CYCLES;
        else if (sof_token)
            sof_gap_r <= 0;
        else if (sof_gap_r < SOF_CYCLES)
            sof_gap_r <= sof_gap_r + 1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            eop_len_r <= 0;
        else if (ls_eop_drive)
            eop_len_r <= eop_len_r + 1;
        else
            eop_len_r <= 0;
    end

    sequence s_rd_pwr;
        hsel && htrans[1] && hready && !hwrite && haddr[7:0] == OFS_PWR;
    endsequence

    property p_pwr_zero;
        s_rd_pwr |=> hrdata[31:8] == 24'h0 && hrdata[6:5] == 2'b00 && !hrdata[2];
    endproperty
    a_pwr_zero: assert property (p_pwr_zero) else $error("spare bits set");

    property p_busy_run;
        s_rd_pwr ##0 module_run |=> hrdata[PWR_BUSY_B];
    endproperty
    a_busy_run: assert property (p_busy_run) else $error("busy low");

    property p_susp_gate;
        pins_usb_owned |-> usb_clk_en != xcvr_low_power;
    endproperty
    a_susp_gate: assert property (p_susp_gate) else $error("gate clash");

    property p_off_core;
        !pins_usb_owned |-> !analog_en && !usb_clk_en && xcvr_low_power && !module_run;
    endproperty
    a_off_core: assert property (p_off_core) else $error("core on while off");

    property p_off_link;
        (!pins_usb_owned)[*3] |-> !resume_drive && !ls_eop_drive && !sof_token && !token_start;
    endproperty
    a_off_link: assert property (p_off_link) else $error("link on while off");

    property p_sof_gap;
        sof_token |-> sof_gap_r >= SOF_CYCLES - 1;
    endproperty
    a_sof_gap: assert property (p_sof_gap) else $error("early frame");

    property p_hr_quiet;
        host_reset |=> (!sof_token)[*8];
    endproperty
    a_hr_quiet: assert property (p_hr_quiet) else $error("frame after reset");

    property p_eop_len;
        $fell(ls_eop_drive) && pins_usb_owned && !host_reset |-> eop_len_r == LS_EOP_CYC;
    endproperty
    a_eop_len: assert property (p_eop_len) else $error("eop length");

    property p_eop_quiet;
        $rose(ls_eop_drive) |-> !resume_drive;
    endproperty
    a_eop_quiet: assert property (p_eop_quiet) else $error("eop with resume");
endmodule : usbpc_top_asserts

bind usbpc_top usbpc_top_asserts #(.SOF_CYCLES(SOF_CYCLES)) i_usbpc_asserts (.*);

//--- dv/usbpc_bus_partner.sv
// Partner: USB far side; activity, buffer completions, token answers.
// Assumes hclk domain; the bench sets slow.
`timescale 1ns/1ps
module usbpc_bus_partner #(
    parameter int NUM_EP = 16
) (
    input  wire logic         hclk,
    input  wire logic         token_start,
    input  wire logic         slow,
    output logic              bus_activity,
    output logic              token_done,
    output logic [NUM_EP-1:0] buf_done
);
    initial
    begin
        bus_activity = 1'b0;
        token_done = 1'b0;
        buf_done = '0;
    end

    task automatic activity();
        @(posedge hclk);
        bus_activity <= 1'b1;
        @(posedge hclk);
        bus_activity <= 1'b0;
    endtask : activity

    task automatic done_mask(input logic [NUM_EP-1:0] m);
        @(posedge hclk);
        buf_done <= m;
        @(posedge hclk);
        buf_done <= '0;
    endtask : done_mask

    // Sampled mid-cycle to stay clear of the launch edge
    always @(negedge hclk)
    begin
        if (token_start)
        begin
            repeat (slow ? 20 : 2) @(posedge hclk);
            token_done <= 1'b1;
            @(posedge hclk);
            token_done <= 1'b0;
        end
    end
endmodule : usbpc_bus_partner

//--- dv/tb.sv
// Bench: directed tests of usbpc_top.
// Assumes the partner model; short frame period.
`timescale 1ns/1ps
module tb;
    import usbpc_pkg::*;
    localparam int SOFC = 50;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        slow = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] haddr = '0;
    logic [31:0] hwdata = '0;
    logic [31:0] q;
    logic [31:0] hrdata;
    logic [15:0] buf_done, pp_odd;
    logic [7:0]  token_code;
    logic hreadyout, hresp, bus_activity, token_done, usb_clk_en, xcvr_low_power;
    logic pins_usb_owned, analog_en, module_run, sleep_block, host_reset, sof_token;
    logic token_start, resume_drive, ls_eop_drive, irq;
    int fails, samples_checked, cyc;
    int sof_n, eop_n, hr_n, ts_n;

    usbpc_top #(.SOF_CYCLES(SOFC)) i_dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .bus_activity, .token_done,
        .buf_done, .usb_clk_en, .xcvr_low_power, .pins_usb_owned, .analog_en, .module_run,
        .sleep_block, .pp_odd, .host_reset, .sof_token, .token_start, .token_code,
        .resume_drive, .ls_eop_drive, .irq
    );
    usbpc_bus_partner i_peer (.hclk, .token_start, .slow, .bus_activity, .token_done, .buf_done);

    initial
    begin
        forever #20 hclk = ~hclk;
    end

    always @(negedge hclk)
    begin
        if (sof_token) sof_n++;
        if (ls_eop_drive) eop_n++;
        if (host_reset) hr_n++;
        if (token_start) ts_n++;
    end

    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            results();
        end
    end

    task automatic results();
        if (fails == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wt(input int n);
        repeat (n) @(negedge hclk);
    endtask : wt

    task automatic ap(input logic [7:0] a, input logic w);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
    endtask : ap

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ap(a, 1'b1);
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        ap(a, 1'b0);
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
        chk(hresp, 1'b0);
    endtask : rd

    task automatic t_regs();
        logic [7:0] ofs [6];
        ofs = '{OFS_PWR, OFS_CTL, OFS_TOK, OFS_IST, OFS_IMSK, 8'h20};
        foreach (ofs[i])
        begin
            rd(ofs[i]);
            chk(q, RST_WORD);
        end
        wr(OFS_PWR, 32'hffff_ffff);
        rd(OFS_PWR);
        chk(q, 32'h13);
        wt(3);
        chk({usb_clk_en, xcvr_low_power}, 2'b01);
        wr(OFS_PWR, 32'h1);
        wt(3);
        chk({usb_clk_en, xcvr_low_power}, 2'b10);
        wr(8'h20, 32'hffff_ffff);
        rd(8'h20);
        chk(q, 32'h0);
    endtask : t_regs

    task automatic t_busy();
        wr(OFS_CTL, 32'h1);
        wt(3);
        chk(module_run, 1'b1);
        rd(OFS_PWR);
        chk(q[PWR_BUSY_B], 1'b1);
        wr(OFS_CTL, 32'h0);
        rd(OFS_PWR);
        chk(q[PWR_BUSY_B], 1'b1);
        wt(15);
        rd(OFS_PWR);
        chk(q, 32'h1);
        chk(module_run, 1'b0);
    endtask : t_busy

    task automatic t_irq();
        wr(OFS_IMSK, 32'h1);
        wr(OFS_PWR, 32'h11);
        i_peer.activity();
        wt(5);
        chk({irq, sleep_block}, 2'b11);
        rd(OFS_IST);
        chk(q, 32'h1);
        wt(3);
        chk({irq, sleep_block}, 2'b00);
        rd(OFS_PWR);
        chk(q, 32'h11);
        wr(OFS_PWR, 32'h1);
        i_peer.activity();
        wt(2);
        chk(sleep_block, 1'b0);
        wr(OFS_IMSK, 32'h0);
        wt(3);
        chk(irq, 1'b0);
        rd(OFS_IST);
        chk(q, 32'h1);
    endtask : t_irq

    task automatic t_pp();
        wr(OFS_CTL, 32'h1);
        i_peer.done_mask(16'h00ff);
        wt(3);
        chk(pp_odd, 16'h00ff);
        wr(OFS_CTL, 32'h3);
        wt(3);
        chk(pp_odd, 16'h0);
        i_peer.done_mask(16'hffff);
        wt(3);
        chk(pp_odd, 16'h0);
        wr(OFS_CTL, 32'h1);
        i_peer.done_mask(16'h0f0f);
        wt(3);
        chk(pp_odd, 16'h0f0f);
    endtask : t_pp

    task automatic t_sof();
        wr(OFS_CTL, 32'h19);
        sof_n = 0;
        wt(4 * SOFC + 20);
        chk(sof_n, 4);
        wr(OFS_CTL, 32'h09);
        sof_n = 0;
        wt(3 * SOFC);
        chk(sof_n, 0);
        hr_n = 0;
        wr(OFS_CTL, 32'h1);
        wt(4);
        chk(hr_n, 1);
    endtask : t_sof

    task automatic t_tok(input logic s);
        slow = s;
        ts_n = 0;
        wr(OFS_TOK, 32'h2d);
        wt(4);
        chk(ts_n, 1);
        chk(token_code, 8'h2d);
        if (s)
        begin
            rd(OFS_CTL);
            chk(q[CTL_TBUSY_B], 1'b1);
            wr(OFS_TOK, 32'h69);
            wt(4);
            chk(ts_n, 1);
        end
        do rd(OFS_CTL); while (q[CTL_TBUSY_B] !== 1'b0);
        rd(OFS_IST);
        chk(q[IRQ_TOK_B], 1'b1);
    endtask : t_tok

    task automatic t_resume();
        wr(OFS_CTL, 32'h0d);
        wt(3);
        chk(resume_drive, 1'b1);
        eop_n = 0;
        wr(OFS_CTL, 32'h09);
        wt(45);
        chk(eop_n, LS_EOP_CYC);
        rd(OFS_IST);
        chk(q[IRQ_EOP_B], 1'b1);
        wr(OFS_CTL, 32'h05);
        wt(3);
        chk(resume_drive, 1'b1);
        eop_n = 0;
        wr(OFS_CTL, 32'h1);
        wt(45);
        chk(eop_n, 0);
        chk(resume_drive, 1'b0);
    endtask : t_resume

    task automatic t_off();
        wr(OFS_PWR, 32'h0);
        wt(3);
        chk({pins_usb_owned, analog_en, module_run, usb_clk_en, xcvr_low_power}, 5'b00001);
    endtask : t_off

    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        wt(3);
        t_regs();
        t_busy();
        t_irq();
        t_pp();
        t_sof();
        t_tok(1'b0);
        t_tok(1'b1);
        t_resume();
        t_off();
        results();
    end
endmodule : tb
